// *** verilog/ctl_params.svh ***
`ifndef CTL_PARAMS_SVH
`define CTL_PARAMS_SVH

`define IDX_TEMP_LOW 8'h60
`define IDX_TEMP_HIGH 8'h61
`define IDX_CMD 8'h62
`define IDX_CLR 8'h63

`define CLR_W 5
`define CLR_RESET 5'h00
`define CMD_RESET 8'h00
`define TEMP_RESET 11'h000
`define TEMP_RSVD 5'h00

`define CMD_PROG 8'h0F
`define CMD_ERASE0 8'h40
`define CMD_ERASE1 8'h41
`define CMD_ERASE2 8'h42
`define CMD_R2F 8'h45
`define CMD_F2R 8'h48
`define CMD_PWRDN 8'hF6

`define PAGE0_BASE 7'h00
`define PAGE1_BASE 7'h20
`define PAGE2_BASE 7'h40
`define PAGE_LAST 5'h1F
`define WAKE_IMMEDIATE 3'h0

`endif

// *** verilog/ctl_pkg.sv ***
`default_nettype none

package ctl_pkg;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_PROG = 3'h1,
        OP_ERASE = 3'h2,
        OP_R2F = 3'h3,
        OP_F2R = 3'h4,
        OP_PWRDN = 3'h5
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FL_WAIT = 3'h1,
        ST_RAM_RD = 3'h2,
        ST_RAM_DATA = 3'h3,
        ST_PD_WAIT = 3'h4,
        ST_SLEEP = 3'h5,
        ST_FINISH = 3'h6
    } state_t;

endpackage : ctl_pkg

`default_nettype wire

// *** verilog/clr_if.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ctl_params.svh"

interface clr_if;
    logic wr;
    logic [`CLR_W-1:0] wdata;
    logic [`CLR_W-1:0] bits;
    logic [`CLR_W-1:0] strobe;
    modport ctrl (output wr, output wdata, input bits, input strobe);
    modport unit (input wr, input wdata, output bits, output strobe);
endinterface : clr_if

`default_nettype wire

// *** verilog/counter_clear_unit.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ctl_params.svh"

module counter_clear_unit (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register side
    clr_if.unit cif
);

    logic [`CLR_W-1:0] bits_ff;
    logic [`CLR_W-1:0] strobe_ff;
    wire [`CLR_W-1:0] nxt_bits;

    // A bit lives one cycle and falls back to zero on the edge that fires its strobe.
    assign nxt_bits = cif.wr ? cif.wdata : `CLR_RESET;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bits_ff <= `CLR_RESET;
            strobe_ff <= `CLR_RESET;
        end
        else
        begin
            bits_ff <= nxt_bits;
            strobe_ff <= bits_ff;
        end
    end

    assign cif.bits = bits_ff;
    assign cif.strobe = strobe_ff;

endmodule : counter_clear_unit

`default_nettype wire

// *** verilog/counter_clear_flash_cmd_temp.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ctl_params.svh"

module counter_clear_flash_cmd_temp (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Counter clear strobes
    output logic charge_time_clear,
    output logic discharge_time_clear,
    output logic self_discharge_clear,
    output logic charge_count_clear,
    output logic discharge_count_clear,
    // Flash programming registers and wake level
    input wire logic [7:0] flash_program_address,
    input wire logic [7:0] flash_program_data,
    input wire logic [2:0] wake_threshold_bits,
    input wire logic sense_below_wake_level,
    // Temperature from the converter
    input wire logic [10:0] temp_value,
    input wire logic temp_valid,
    // Flash array port
    output logic flash_req,
    output logic flash_we,
    output logic flash_erase,
    output logic [6:0] flash_addr,
    output logic [7:0] flash_wdata,
    input wire logic flash_ack,
    input wire logic [7:0] flash_rdata,
    // General-purpose RAM port
    output logic ram_we,
    output logic [4:0] ram_addr,
    output logic [7:0] ram_wdata,
    input wire logic [7:0] ram_rdata,
    // Power state
    input wire logic single_wire_serial_pin,
    output logic sleep_mode
);

    // ****************************************************
    // Command decode
    // ****************************************************

    function automatic ctl_pkg::op_t decode_op(input logic [7:0] code);
        case (code)
            `CMD_PROG: decode_op = ctl_pkg::OP_PROG;
            `CMD_ERASE0: decode_op = ctl_pkg::OP_ERASE;
            `CMD_ERASE1: decode_op = ctl_pkg::OP_ERASE;
            `CMD_ERASE2: decode_op = ctl_pkg::OP_ERASE;
            `CMD_R2F: decode_op = ctl_pkg::OP_R2F;
            `CMD_F2R: decode_op = ctl_pkg::OP_F2R;
            `CMD_PWRDN: decode_op = ctl_pkg::OP_PWRDN;
            default: decode_op = ctl_pkg::OP_NONE;
        endcase
    endfunction : decode_op

    function automatic logic [6:0] erase_base(input logic [7:0] code);
        case (code)
            `CMD_ERASE1: erase_base = `PAGE1_BASE;
            `CMD_ERASE2: erase_base = `PAGE2_BASE;
            default: erase_base = `PAGE0_BASE;
        endcase
    endfunction : erase_base

    // ****************************************************
    // Bus slave
    // ****************************************************

    logic wait_ff;
    logic [31:0] rdata_ff;
    wire [7:0] reg_index;
    wire access;
    wire commit_wr;
    wire hit_temp_low;
    wire hit_temp_high;
    wire hit_cmd;
    wire hit_clr;
    wire wr_cmd;
    wire [7:0] wbyte;
    wire [7:0] rd_byte;

    logic [10:0] temp_ff;
    logic [7:0] cmd_ff;

    clr_if cif ();

    // A request is seen with waitrequest high, answered one cycle later.
    assign reg_index = avs_address[9:2];
    assign access = (avs_read | avs_write) & wait_ff;
    assign commit_wr = avs_write & ~wait_ff & avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign hit_temp_low = reg_index == `IDX_TEMP_LOW;
    assign hit_temp_high = reg_index == `IDX_TEMP_HIGH;
    assign hit_cmd = reg_index == `IDX_CMD;
    assign hit_clr = reg_index == `IDX_CLR;
    assign wr_cmd = commit_wr & hit_cmd;

    // Reserved clear bits are dropped; only the five clear bits are kept.
    assign cif.wr = commit_wr & hit_clr;
    assign cif.wdata = wbyte[`CLR_W-1:0];

    assign rd_byte = hit_temp_low ? temp_ff[7:0] :
        hit_temp_high ? {`TEMP_RSVD, temp_ff[10:8]} :
        hit_cmd ? cmd_ff :
        hit_clr ? {3'h0, cif.bits} :
        8'h00;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h00000000;
        end
        else
        begin
            wait_ff <= ~access;
            rdata_ff <= (access & avs_read) ? {24'h000000, rd_byte} : rdata_ff;
        end
    end

    assign avs_waitrequest = wait_ff;
    assign avs_readdata = rdata_ff;

    // ****************************************************
    // Counter clear
    // ****************************************************

    counter_clear_unit u_clear (
        .clk(clk),
        .nrst(nrst),
        .cif(cif)
    );

    // Time clears also reset the matching rollover flag downstream.
    assign charge_time_clear = cif.strobe[4];
    assign discharge_time_clear = cif.strobe[3];
    assign self_discharge_clear = cif.strobe[2];
    assign charge_count_clear = cif.strobe[1];
    assign discharge_count_clear = cif.strobe[0];

    // ****************************************************
    // Temperature
    // ****************************************************

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            temp_ff <= `TEMP_RESET;
        else if (temp_valid)
            temp_ff <= temp_value;
    end

    // ****************************************************
    // Command sequencer
    // ****************************************************

    ctl_pkg::state_t state_ff;
    ctl_pkg::state_t nxt_state;
    ctl_pkg::op_t op_ff;
    ctl_pkg::op_t nxt_op;
    logic [7:0] nxt_cmd;
    logic [4:0] idx_ff;
    logic [4:0] nxt_idx;
    logic [7:0] fpd_ff;
    logic [7:0] nxt_fpd;
    logic nxt_freq;
    logic nxt_fwe;
    logic nxt_ferase;
    logic [6:0] nxt_faddr;
    logic [7:0] nxt_fwdata;
    logic nxt_ram_we;
    logic [4:0] nxt_ram_addr;
    logic [7:0] nxt_ram_wdata;
    logic nxt_sleep;
    logic pin_prev_ff;

    wire ctl_pkg::op_t new_op;
    wire sleep_cond;
    wire pin_edge;
    wire was_read;
    wire last_idx;
    wire [4:0] idx_inc;

    assign new_op = decode_op(wbyte);
    assign sleep_cond = (wake_threshold_bits == `WAKE_IMMEDIATE) | sense_below_wake_level;
    assign pin_edge = single_wire_serial_pin ^ pin_prev_ff;
    assign was_read = ~flash_we & ~flash_erase;
    assign last_idx = idx_ff == `PAGE_LAST;
    assign idx_inc = idx_ff + 5'h01;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_cmd = cmd_ff;
        nxt_idx = idx_ff;
        nxt_fpd = fpd_ff;
        nxt_freq = flash_req;
        nxt_fwe = flash_we;
        nxt_ferase = flash_erase;
        nxt_faddr = flash_addr;
        nxt_fwdata = flash_wdata;
        nxt_ram_we = 1'b0;
        nxt_ram_addr = ram_addr;
        nxt_ram_wdata = ram_wdata;
        nxt_sleep = sleep_mode;
        case (state_ff)
            ctl_pkg::ST_IDLE:
            begin
                // Writes that arrive while a command runs are ignored.
                if (wr_cmd && wbyte != `CMD_RESET)
                begin
                    nxt_cmd = wbyte;
                    nxt_op = new_op;
                    nxt_fpd = flash_program_data;
                    nxt_idx = 5'h00;
                    case (new_op)
                        ctl_pkg::OP_PROG:
                        begin
                            nxt_freq = 1'b1;
                            nxt_fwe = 1'b0;
                            nxt_faddr = flash_program_address[6:0];
                            nxt_state = ctl_pkg::ST_FL_WAIT;
                        end
                        ctl_pkg::OP_ERASE:
                        begin
                            nxt_freq = 1'b1;
                            nxt_ferase = 1'b1;
                            nxt_faddr = erase_base(wbyte);
                            nxt_state = ctl_pkg::ST_FL_WAIT;
                        end
                        ctl_pkg::OP_R2F:
                        begin
                            nxt_ram_addr = 5'h00;
                            nxt_state = ctl_pkg::ST_RAM_RD;
                        end
                        ctl_pkg::OP_F2R:
                        begin
                            nxt_freq = 1'b1;
                            nxt_fwe = 1'b0;
                            nxt_faddr = `PAGE0_BASE;
                            nxt_state = ctl_pkg::ST_FL_WAIT;
                        end
                        ctl_pkg::OP_PWRDN:
                            nxt_state = ctl_pkg::ST_PD_WAIT;
                        default:
                            nxt_state = ctl_pkg::ST_FINISH;
                    endcase
                end
            end
            ctl_pkg::ST_FL_WAIT:
            begin
                if (flash_ack)
                begin
                    nxt_freq = 1'b0;
                    nxt_ferase = 1'b0;
                    nxt_fwe = 1'b0;
                    nxt_state = ctl_pkg::ST_FINISH;
                    if (was_read && op_ff == ctl_pkg::OP_PROG)
                    begin
                        // Program can only clear bits, so the old byte is merged.
                        nxt_freq = 1'b1;
                        nxt_fwe = 1'b1;
                        nxt_fwdata = flash_rdata & fpd_ff;
                        nxt_state = ctl_pkg::ST_FL_WAIT;
                    end
                    else if (was_read && op_ff == ctl_pkg::OP_F2R)
                    begin
                        nxt_ram_we = 1'b1;
                        nxt_ram_addr = idx_ff;
                        nxt_ram_wdata = flash_rdata;
                        if (!last_idx)
                        begin
                            nxt_idx = idx_inc;
                            nxt_freq = 1'b1;
                            nxt_faddr = {2'b00, idx_inc};
                            nxt_state = ctl_pkg::ST_FL_WAIT;
                        end
                    end
                    else if (op_ff == ctl_pkg::OP_R2F && !last_idx)
                    begin
                        nxt_idx = idx_inc;
                        nxt_ram_addr = idx_inc;
                        nxt_state = ctl_pkg::ST_RAM_RD;
                    end
                end
            end
            ctl_pkg::ST_RAM_RD:
                nxt_state = ctl_pkg::ST_RAM_DATA;
            ctl_pkg::ST_RAM_DATA:
            begin
                nxt_freq = 1'b1;
                nxt_fwe = 1'b1;
                nxt_faddr = {2'b00, idx_ff};
                nxt_fwdata = ram_rdata;
                nxt_state = ctl_pkg::ST_FL_WAIT;
            end
            ctl_pkg::ST_PD_WAIT:
            begin
                if (sleep_cond)
                begin
                    nxt_sleep = 1'b1;
                    nxt_cmd = `CMD_RESET;
                    nxt_state = ctl_pkg::ST_SLEEP;
                end
            end
            ctl_pkg::ST_SLEEP:
            begin
                if (pin_edge)
                begin
                    nxt_sleep = 1'b0;
                    nxt_state = ctl_pkg::ST_IDLE;
                end
            end
            ctl_pkg::ST_FINISH:
            begin
                nxt_cmd = `CMD_RESET;
                nxt_op = ctl_pkg::OP_NONE;
                nxt_state = ctl_pkg::ST_IDLE;
            end
            default:
                nxt_state = ctl_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ctl_pkg::ST_IDLE;
            op_ff <= ctl_pkg::OP_NONE;
            cmd_ff <= `CMD_RESET;
            idx_ff <= 5'h00;
            fpd_ff <= 8'h00;
            sleep_mode <= 1'b0;
            // The serial line idles high, so no false edge follows reset.
            pin_prev_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            cmd_ff <= nxt_cmd;
            idx_ff <= nxt_idx;
            fpd_ff <= nxt_fpd;
            sleep_mode <= nxt_sleep;
            pin_prev_ff <= single_wire_serial_pin;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            flash_req <= 1'b0;
            flash_we <= 1'b0;
            flash_erase <= 1'b0;
            flash_addr <= 7'h00;
            flash_wdata <= 8'h00;
        end
        else
        begin
            flash_req <= nxt_freq;
            flash_we <= nxt_fwe;
            flash_erase <= nxt_ferase;
            flash_addr <= nxt_faddr;
            flash_wdata <= nxt_fwdata;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ram_we <= 1'b0;
            ram_addr <= 5'h00;
            ram_wdata <= 8'h00;
        end
        else
        begin
            ram_we <= nxt_ram_we;
            ram_addr <= nxt_ram_addr;
            ram_wdata <= nxt_ram_wdata;
        end
    end

endmodule : counter_clear_flash_cmd_temp

`default_nettype wire

// *** verification/flash_ram_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ********
// Flash array and RAM seen from the block
// ********
module flash_ram_model (
    // Clock and pacing
    input wire logic clk,
    input wire logic slow,
    // Flash port
    input wire logic flash_req,
    input wire logic flash_we,
    input wire logic flash_erase,
    input wire logic [6:0] flash_addr,
    input wire logic [7:0] flash_wdata,
    output logic flash_ack,
    output logic [7:0] flash_rdata,
    // RAM port
    input wire logic ram_we,
    input wire logic [4:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    output logic [7:0] ram_rdata
);
    logic [7:0] mem [128];
    logic [7:0] ram [32];
    logic [7:0] rd_ff = 8'h00;
    logic [2:0] cnt = 3'h0;

    initial
    begin
        flash_ack = 1'b0;
        ram_rdata = 8'h00;
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i) ^ 8'h5A;
        for (int i = 0; i < 32; i++)
            ram[i] = 8'hC0 | 8'(i);
    end

    // Outside an acknowledge the data lines show no stale value.
    assign flash_rdata = flash_ack ? rd_ff : ~rd_ff;

    // Programming only clears bits, as real flash cells do.
    always @(posedge clk)
    begin
        flash_ack <= 1'b0;
        ram_rdata <= ram[ram_addr];
        if (ram_we)
            ram[ram_addr] <= ram_wdata;
        if (flash_req && !flash_ack)
        begin
            if (cnt < (slow ? 3'h5 : 3'h0))
                cnt <= cnt + 3'h1;
            else
            begin
                cnt <= 3'h0;
                flash_ack <= 1'b1;
                rd_ff <= mem[flash_addr];
                if (flash_erase)
                    for (int i = 0; i < 32; i++)
                        mem[{flash_addr[6:5], 5'(i)}] <= 8'hFF;
                else if (flash_we)
                    mem[flash_addr] <= mem[flash_addr] & flash_wdata;
            end
        end
    end
endmodule : flash_ram_model

`default_nettype wire

// *** verification/cmd_temp_props.sv ***
`timescale 1ns/10ps
`default_nettype none

// ********
// Port checker
// ********
module cmd_temp_props (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register bus
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Clear strobes
    input wire logic charge_time_clear,
    input wire logic discharge_time_clear,
    input wire logic self_discharge_clear,
    input wire logic charge_count_clear,
    input wire logic discharge_count_clear,
    // Flash and power
    input wire logic flash_req,
    input wire logic flash_erase,
    input wire logic flash_ack,
    input wire logic [6:0] flash_addr,
    input wire logic single_wire_serial_pin,
    input wire logic sleep_mode
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!nrst);

    wire logic [4:0] strobes = {charge_time_clear, discharge_time_clear,
        self_discharge_clear, charge_count_clear, discharge_count_clear};
    wire logic [4:0] wdata5 = avs_writedata[4:0];
    wire logic wr_clr = avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address[9:2] == 8'h63;
    wire logic pin = single_wire_serial_pin;

    AST_WAIT_ONE:
    assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("Bus answer not in the cycle after the request.");
    AST_WAIT_PULSE:
    assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Bus answer held longer than one cycle.");
    AST_TEMP_RSVD:
    assert property (avs_read && !avs_waitrequest && avs_address[9:2] == 8'h61
        |-> avs_readdata[7:3] == 5'h00)
        else $error("Temperature high byte upper bits not zero.");
    AST_CLEAR_STROBE:
    assert property (wr_clr |-> ##2 strobes == $past(wdata5, 2))
        else $error("Clear strobes do not match the written bits.");
    AST_STROBE_CAUSE:
    assert property (strobes != 5'h00 |-> $past(wr_clr, 2) ##1 strobes == 5'h00)
        else $error("Clear strobe without a write or longer than a cycle.");
    AST_FLASH_HOLD:
    assert property (flash_req && !flash_ack |=> flash_req)
        else $error("Flash request dropped before acknowledge.");
    AST_ERASE_BASE:
    assert property (flash_req && flash_erase
        |-> flash_addr[4:0] == 5'h00 && flash_addr <= 7'h40)
        else $error("Erase not at a page base.");
    AST_SLEEP_HOLD:
    assert property (sleep_mode && $stable(pin) && $past(pin) == $past(pin, 2)
        |=> sleep_mode)
        else $error("Sleep left without a pin change.");
    AST_WAKE:
    assert property (sleep_mode && $changed(pin) |-> ##[1:3] !sleep_mode)
        else $error("Sleep not left after a pin change.");

    cover property (wr_clr);
    cover property (flash_req && flash_erase);
    cover property ($rose(sleep_mode));
endmodule : cmd_temp_props

bind counter_clear_flash_cmd_temp cmd_temp_props props_i (.clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .charge_time_clear(charge_time_clear), .discharge_time_clear(discharge_time_clear),
    .self_discharge_clear(self_discharge_clear), .charge_count_clear(charge_count_clear),
    .discharge_count_clear(discharge_count_clear), .flash_req(flash_req),
    .flash_erase(flash_erase), .flash_ack(flash_ack), .flash_addr(flash_addr),
    .single_wire_serial_pin(single_wire_serial_pin), .sleep_mode(sleep_mode));

`default_nettype wire

// *** verification/counter_clear_flash_cmd_temp_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module counter_clear_flash_cmd_temp_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    wire logic [4:0] strobes;
    logic [7:0] prog_addr = 8'h00;
    logic [7:0] prog_data = 8'h00;
    logic [2:0] wake = 3'h7;
    logic below = 1'b0;
    logic [10:0] temp = 11'h000;
    logic temp_valid = 1'b0;
    logic flash_req, flash_we, flash_erase, flash_ack, ram_we, sleep_mode;
    logic [6:0] flash_addr;
    logic [7:0] flash_wdata, flash_rdata, ram_wdata, ram_rdata, q;
    logic [4:0] ram_addr;
    logic pin = 1'b1;
    logic slow = 1'b0;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;

    counter_clear_flash_cmd_temp uut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .charge_time_clear(strobes[4]),
        .discharge_time_clear(strobes[3]), .self_discharge_clear(strobes[2]),
        .charge_count_clear(strobes[1]), .discharge_count_clear(strobes[0]),
        .flash_program_address(prog_addr), .flash_program_data(prog_data),
        .wake_threshold_bits(wake), .sense_below_wake_level(below), .temp_value(temp),
        .temp_valid(temp_valid), .flash_req(flash_req), .flash_we(flash_we),
        .flash_erase(flash_erase), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_ack(flash_ack), .flash_rdata(flash_rdata), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
        .single_wire_serial_pin(pin), .sleep_mode(sleep_mode));

    flash_ram_model m (.clk(clk), .slow(slow), .flash_req(flash_req), .flash_we(flash_we),
        .flash_erase(flash_erase), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_ack(flash_ack), .flash_rdata(flash_rdata), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));

    always #10 clk = ~clk;

    // ********
    // Shared tasks
    // ********
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            close_out();
        end
    end

    task check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // The request stands until the edge that samples the answer.
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h000000, d};
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task run_cmd(input logic [7:0] code);
        bus(1'b1, 8'h62, code);
        bus(1'b0, 8'h62, 8'h00);
        for (int n = 0; n < 300 && q !== 8'h00; n++)
            bus(1'b0, 8'h62, 8'h00);
        check(q, 8'h00);
    endtask : run_cmd

    task wait_sleep(input logic v);
        for (int n = 0; n < 12 && sleep_mode !== v; n++)
            @(posedge clk);
        check({7'h00, sleep_mode}, {7'h00, v});
    endtask : wait_sleep

    // ********
    // Scenarios
    // ********
    task t_map;
        bus(1'b0, 8'h63, 8'h00);
        check(q, 8'h00);
        bus(1'b1, 8'h10, 8'h5A);
        bus(1'b0, 8'h10, 8'h00);
        check(q, 8'h00);
    endtask : t_map

    task t_clear;
        logic [4:0] seen, data;
        for (int b = 0; b < 7; b++)
        begin
            data = (b >= 5) ? 5'h1F : 5'(1 << b);
            avs_byteenable <= (b == 6) ? 4'h0 : 4'hF;
            bus(1'b1, 8'h63, {3'b000, data});
            seen = 5'h00;
            repeat (4)
            begin
                @(posedge clk);
                seen |= strobes;
            end
            check({3'h0, seen}, (b == 6) ? 8'h00 : {3'h0, data});
            bus(1'b0, 8'h63, 8'h00);
            check(q, 8'h00);
        end
        avs_byteenable <= 4'hF;
    endtask : t_clear

    task t_temp;
        temp <= 11'h7A5;
        temp_valid <= 1'b1;
        @(posedge clk);
        temp_valid <= 1'b0;
        bus(1'b0, 8'h60, 8'h00);
        check(q, 8'hA5);
        bus(1'b0, 8'h61, 8'h00);
        check(q & 8'h07, 8'h07);
        check(q, 8'h07);
    endtask : t_temp

    task t_flash;
        logic [7:0] code;
        logic [6:0] base;
        prog_addr <= 8'hE5;
        prog_data <= 8'h3C;
        run_cmd(8'h0F);
        check(m.mem[7'h65], (8'h65 ^ 8'h5A) & 8'h3C);
        for (int k = 0; k < 3; k++)
        begin
            code = 8'h40 + 8'((k + 1) % 3);
            base = {code[1:0], 5'h00};
            slow <= k[0];
            run_cmd(code);
            check(m.mem[base], 8'hFF);
            check(m.mem[base + 7'h1F], 8'hFF);
            check(m.mem[7'h65], 8'h3C);
            if (k == 0)
                check(m.mem[7'h40], 8'h1A);
        end
        slow <= 1'b1;
        run_cmd(8'h45);
        for (int i = 0; i < 32; i++)
            check(m.mem[i], 8'hC0 | 8'(i));
        slow <= 1'b0;
        run_cmd(8'h40);
        run_cmd(8'h48);
        for (int i = 0; i < 32; i++)
            check(m.ram[i], 8'hFF);
        run_cmd(8'h33);
        check(m.mem[7'h65], 8'h3C);
        check(m.mem[7'h00], 8'hFF);
    endtask : t_flash

    task t_sleep;
        wake <= 3'h2;
        below <= 1'b0;
        bus(1'b1, 8'h62, 8'hF6);
        repeat (10) @(posedge clk);
        wait_sleep(1'b0);
        bus(1'b0, 8'h62, 8'h00);
        check(q, 8'hF6);
        below <= 1'b1;
        wait_sleep(1'b1);
        bus(1'b0, 8'h62, 8'h00);
        check(q, 8'h00);
        below <= 1'b0;
        repeat (20) @(posedge clk);
        wait_sleep(1'b1);
        pin <= 1'b0;
        wait_sleep(1'b0);
        wake <= 3'h0;
        bus(1'b1, 8'h62, 8'hF6);
        wait_sleep(1'b1);
        pin <= 1'b1;
        wait_sleep(1'b0);
    endtask : t_sleep

    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_map();
        t_clear();
        t_temp();
        t_flash();
        t_sleep();
        close_out();
    end
endmodule : counter_clear_flash_cmd_temp_test

`default_nettype wire
